/* File: rtl/atb_timer.sv */
// Time-base unit of an advanced timer with an AXI4-Lite register slave
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - 16-bit counter with auto-reload counts up, down or centre-aligned.
// - Auto-reload access hits preload; active copy follows at once or at update.
// - Counter steps only on prescaled ticks while enabled, one cycle after enabling.
// - Prescaler divides by 1 to 65536 with a 16-bit counter and value.
// - New prescaler value is buffered and applied from the next update.
// - Up mode counts 0 to auto-reload, wraps to 0, signals overflow.
// - Up mode updates after repetition plus one overflows, else each overflow.
// - Down mode counts auto-reload to 0, reloads, signals underflow.
// - Down mode without repetition updates on every underflow.
// - Update-generate bit produces an update in every mode.
// - Update-disable blocks all updates until written back to zero.
// - Update-generate in up mode restarts counter and prescaler counter at 0.
// - Update-generate in down mode restarts counter at auto-reload, prescaler at 0.
// - With request-select set, software update skips the update flag.
// - Update reloads repetition, auto-reload and prescaler, sets flag unless suppressed.
// - Down mode refreshes auto-reload before reloading counter at underflow.
// - Centre mode counts 0 to reload-1 overflow, reload down to 1 underflow.
// - Centre field 00 selects edge mode; 01, 10, 11 select centre modes.
// - In centre mode direction ignores writes and shows hardware direction.
// - Centre mode updates on overflow and underflow; software update zeroes counters.
// - Centre mode with updates disabled keeps counting on active reload.
// - Centre mode overflow update refreshes auto-reload before counter reloads.
// - Update-generate self-clears; enable and direction stay software bits.
module atb_timer #(
  parameter int CW = 16,
  parameter int RW = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AXI4-Lite write channels
  input wire logic [atb_pkg::ATB_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [atb_pkg::ATB_DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [atb_pkg::ATB_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [atb_pkg::ATB_DW-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Timer status
  output logic update_event_out,
  output logic count_down_out
);
  import atb_pkg::*;

  // Applies byte strobes to a register word
  function automatic logic [ATB_DW-1:0] merge(input logic [ATB_DW-1:0] old,
      input logic [ATB_DW-1:0] nw, input logic [3:0] strb);
    logic [ATB_DW-1:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Address map check
  function automatic logic mapped(input logic [ATB_AW-1:0] a);
    return a == ATB_CTRL_OFF || a == ATB_FLAG_OFF || a == ATB_EGR_OFF || a == ATB_CNT_OFF
        || a == ATB_PSC_OFF || a == ATB_ARR_OFF || a == ATB_RCR_OFF;
  endfunction : mapped

  // ****************************************
  // State
  // ****************************************
  atb_ctrl_s ctrl;
  logic flag;
  logic ug_req;
  logic [CW-1:0] cnt;
  logic [CW-1:0] psc_pre;
  logic [CW-1:0] psc_act;
  logic [CW-1:0] psc_cnt;
  logic [CW-1:0] arr_pre;
  logic [CW-1:0] arr_act;
  logic [RW-1:0] rcr;
  logic [RW-1:0] rep_cnt;
  logic dir_hw;
  logic [ATB_AW-1:0] wr_addr;
  logic [ATB_DW-1:0] wr_data;
  logic [3:0] wr_strb;

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic wr_go;
  logic [ATB_DW-1:0] wr_word;
  logic [ATB_DW-1:0] rd_word;
  assign wr_go = !awready && !wready && !bvalid;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= ATB_RESP_OK;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= mapped(wr_addr) ? ATB_RESP_OK : ATB_RESP_ERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_word = '0;
    unique case (araddr)
      ATB_CTRL_OFF: rd_word = ATB_DW'({ctrl.auto_reload_preload_enable, ctrl.center_mode_select,
          (ctrl.center_mode_select != ATB_CMS_EDGE) ? dir_hw : ctrl.dir, ctrl.update_request_select, ctrl.update_disable, ctrl.counter_enable_bit});
      ATB_FLAG_OFF: rd_word[ATB_FLAG_BIT] = flag;
      ATB_CNT_OFF: rd_word = ATB_DW'(cnt);
      ATB_PSC_OFF: rd_word = ATB_DW'(psc_pre);
      ATB_ARR_OFF: rd_word = ATB_DW'(arr_pre);
      ATB_RCR_OFF: rd_word = ATB_DW'(rcr);
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= ATB_RESP_OK;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= mapped(araddr) ? ATB_RESP_OK : ATB_RESP_ERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Register write strobes
  // ****************************************
  logic wr_ctrl, wr_flag, wr_egr, wr_cnt, wr_psc, wr_arr, wr_rcr;
  assign wr_word = merge('0, wr_data, wr_strb);
  assign wr_ctrl = wr_go && wr_addr == ATB_CTRL_OFF;
  assign wr_flag = wr_go && wr_addr == ATB_FLAG_OFF && wr_strb[0];
  assign wr_egr = wr_go && wr_addr == ATB_EGR_OFF && wr_strb[0];
  assign wr_cnt = wr_go && wr_addr == ATB_CNT_OFF;
  assign wr_psc = wr_go && wr_addr == ATB_PSC_OFF;
  assign wr_arr = wr_go && wr_addr == ATB_ARR_OFF;
  assign wr_rcr = wr_go && wr_addr == ATB_RCR_OFF;

  // ****************************************
  // Time-base decisions
  // ****************************************
  logic center, down, tick, ovf, unf, hw_ev, rep_zero, update_event;
  logic [CW-1:0] arr_eff;
  logic [CW-1:0] cnt_inc;
  assign cnt_inc = cnt + CW'(1);
  assign center = ctrl.center_mode_select != ATB_CMS_EDGE;
  assign down = center ? dir_hw : ctrl.dir;
  assign tick = ctrl.counter_enable_bit && psc_cnt == psc_act;
  assign ovf = tick && !down && (center ? cnt_inc >= arr_act : cnt >= arr_act);
  assign unf = tick && down && (center ? cnt <= CW'(1) : cnt == '0);
  assign hw_ev = ovf || unf;
  assign rep_zero = rep_cnt == '0;
  assign update_event = !ctrl.update_disable && (ug_req || (hw_ev && rep_zero));
  assign arr_eff = (!ctrl.auto_reload_preload_enable || update_event) ? arr_pre : arr_act;

  // Control bits; the generate request clears itself the next cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl <= '0;
      ug_req <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= atb_ctrl_s'(wr_word[ATB_CTRL_W-1:0]);
      end
      ug_req <= wr_egr && wr_word[ATB_UG_BIT];
    end
  end

  // Update flag: hardware set beats the software clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (update_event && !(ug_req && ctrl.update_request_select)) begin
      flag <= 1'b1;
    end else if (wr_flag && !wr_word[ATB_FLAG_BIT]) begin
      flag <= 1'b0;
    end
  end

  // Preload and active copies
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      psc_pre <= '0;
      psc_act <= '0;
      arr_pre <= CW'(ATB_ARR_RST);
      arr_act <= CW'(ATB_ARR_RST);
      rcr <= '0;
    end else begin
      if (wr_psc) begin
        psc_pre <= wr_word[CW-1:0];
      end
      if (wr_arr) begin
        arr_pre <= wr_word[CW-1:0];
      end
      if (wr_rcr) begin
        rcr <= wr_word[RW-1:0];
      end
      if (update_event) begin
        psc_act <= psc_pre;
      end
      arr_act <= arr_eff;
    end
  end

  // Prescaler counter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      psc_cnt <= '0;
    end else if (ug_req || tick) begin
      psc_cnt <= '0;
    end else if (ctrl.counter_enable_bit) begin
      psc_cnt <= psc_cnt + CW'(1);
    end
  end

  // Repetition counter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rep_cnt <= '0;
    end else if (update_event || (hw_ev && rep_zero)) begin
      rep_cnt <= rcr;
    end else if (hw_ev) begin
      rep_cnt <= rep_cnt - RW'(1);
    end
  end

  // Main counter
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (wr_cnt) begin
      cnt <= wr_word[CW-1:0];
    end else if (ug_req) begin
      cnt <= (!center && ctrl.dir) ? arr_eff : '0;
    end else if (tick) begin
      if (center) begin
        cnt <= down ? cnt - CW'(1) : (ovf ? arr_eff : cnt_inc);
      end else if (down) begin
        cnt <= unf ? arr_eff : cnt - CW'(1);
      end else begin
        cnt <= ovf ? '0 : cnt_inc;
      end
    end
  end

  // Hardware direction in centre mode
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dir_hw <= 1'b0;
    end else if (!center || ug_req || unf) begin
      dir_hw <= 1'b0;
    end else if (ovf) begin
      dir_hw <= 1'b1;
    end
  end

  // Status outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      update_event_out <= 1'b0;
      count_down_out <= 1'b0;
    end else begin
      update_event_out <= update_event;
      count_down_out <= down;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_quiet;
    !wr_cnt && !ug_req;
  endsequence

  a_ug_self_clear: assert property (ug_req |=> !ug_req)
    else $error("update request did not clear");
  a_update_disable_blocks: assert property ($past(ctrl.update_disable) |-> !update_event_out)
    else $error("update while disabled");
  a_up_wrap: assert property ((!center && !ctrl.dir && ovf) and s_quiet |=> cnt == '0)
    else $error("up count did not wrap to zero");
  a_down_reload: assert property ((!center && ctrl.dir && unf) and s_quiet |=> cnt == arr_act)
    else $error("down count reload mismatch");
  a_ug_restart: assert property (ug_req && !wr_cnt && !(!center && ctrl.dir)
      |=> cnt == '0 && psc_cnt == '0)
    else $error("software update did not restart");
  a_urs_no_flag: assert property (ug_req && ctrl.update_request_select && !hw_ev && !flag |=> !flag)
    else $error("flag set by suppressed update");
  a_uev_loads: assert property (update_event |=> psc_act == $past(psc_pre) && rep_cnt == $past(rcr))
    else $error("update did not reload copies");
  a_rep_gate: assert property (hw_ev && !rep_zero && !ug_req |=> !update_event_out)
    else $error("update before repetition ran out");
  a_cen_hold: assert property ((!ctrl.counter_enable_bit) and s_quiet |=> $stable(cnt))
    else $error("counter moved while disabled");
  a_center_dir: assert property (center && ovf && !ug_req ##1 center |-> dir_hw)
    else $error("direction not down after overflow");
endmodule : atb_timer

`default_nettype wire

/* File: include/atb_pkg.sv */
// Shared constants and types for the timer time-base block
package atb_pkg;
  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int ATB_AW = 8;
  localparam int ATB_DW = 32;
  localparam logic [ATB_AW-1:0] ATB_CTRL_OFF = 8'h00;
  localparam logic [ATB_AW-1:0] ATB_FLAG_OFF = 8'h04;
  localparam logic [ATB_AW-1:0] ATB_EGR_OFF = 8'h08;
  localparam logic [ATB_AW-1:0] ATB_CNT_OFF = 8'h0C;
  localparam logic [ATB_AW-1:0] ATB_PSC_OFF = 8'h10;
  localparam logic [ATB_AW-1:0] ATB_ARR_OFF = 8'h14;
  localparam logic [ATB_AW-1:0] ATB_RCR_OFF = 8'h18;
  localparam logic [1:0] ATB_RESP_OK = 2'h0;
  localparam logic [1:0] ATB_RESP_ERR = 2'h2;
  localparam int ATB_FLAG_BIT = 0;
  localparam int ATB_UG_BIT = 0;
  localparam int ATB_CTRL_W = 7;
  localparam logic [1:0] ATB_CMS_EDGE = 2'h0;
  localparam logic [15:0] ATB_ARR_RST = 16'hFFFF;

  // ****************************************
  // Control register layout, bit 6 downward to bit 0
  // ****************************************
  typedef struct packed {
    logic auto_reload_preload_enable;
    logic [1:0] center_mode_select;
    logic dir;
    logic update_request_select;
    logic update_disable;
    logic counter_enable_bit;
  } atb_ctrl_s;
endpackage : atb_pkg

/* File: testbench/advanced_timer_time_base_bench.sv */
// Self-checking bench for the timer time-base block
`timescale 1ns/1ps
`default_nettype none
module advanced_timer_time_base_bench;
  import atb_pkg::*;
  // ****************************************
  // Stimulus signals and scoreboard
  // ****************************************
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ATB_AW-1:0] awaddr = '0;
  logic [ATB_AW-1:0] araddr = '0;
  logic [ATB_DW-1:0] wdata = '0;
  logic [ATB_DW-1:0] rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, update_event_out, count_down_out;
  logic [1:0] bresp, rresp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int gq[$];
  int fail_count = 0, checks_done = 0, cyc = 0, last = 0, npulse = 0;
  logic [7:0] seed = 8'h2E;
  atb_ctrl_s c;

  always #25 ref_clk = ~ref_clk;

  atb_timer #(.CW(16), .RW(8)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .update_event_out(update_event_out),
    .count_down_out(count_down_out));

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // Pseudo-random source for the programmed divide, reload and repetition values
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic timeout;
    fail_count++;
    conclude();
  endtask : timeout

  // Oldest note is taken off whenever a result shows at the outputs
  always @(posedge ref_clk) begin
    cyc++;
    if (rvalid && rready && rq.size() > 0) check({rresp, rdata}, rq.pop_front());
    if (bvalid && bready && bq.size() > 0) check({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (update_event_out) begin
      npulse++;
      if (gq.size() > 0) check(34'(cyc - last), 34'(gq.pop_front()));
      last = cyc;
    end
  end

  // ****************************************
  // Bus cycles
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = ATB_RESP_OK);
    int n;
    bit ta, tw;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ta = 0;
    tw = 0;
    for (n = 0; n < 50 && !(ta && tw); n++) begin
      @(posedge ref_clk);
      if (awready && !ta) begin
        ta = 1;
        awvalid <= 1'b0;
      end
      if (wready && !tw) begin
        tw = 1;
        wvalid <= 1'b0;
      end
    end
    for (n = 0; n < 50 && !bvalid; n++) @(posedge ref_clk);
    if (n == 50 || !ta || !tw) timeout();
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = ATB_RESP_OK);
    int n;
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (arready) break;
    end
    arvalid <= 1'b0;
    if (n == 50) timeout();
    for (n = 0; n < 50 && !rvalid; n++) @(posedge ref_clk);
    if (n == 50) timeout();
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask : rd

  task automatic pulse;
    int n;
    for (n = 0; n < 4000; n++) begin
      @(posedge ref_clk);
      if (update_event_out) break;
    end
    if (n == 4000) timeout();
  endtask : pulse

  // Period between update pulses for one counting mode
  task automatic run_mode(input logic [1:0] center_mode_select, input logic dir, input int p, input int a, input int r, input int gap);
    c = '0;
    c.center_mode_select = center_mode_select;
    c.dir = dir;
    wr(ATB_PSC_OFF, 32'(p));
    wr(ATB_ARR_OFF, 32'(a));
    wr(ATB_RCR_OFF, 32'(r));
    wr(ATB_CTRL_OFF, 32'(c));
    wr(ATB_EGR_OFF, 32'h1);
    c.counter_enable_bit = 1'b1;
    wr(ATB_CTRL_OFF, 32'(c));
    pulse();
    pulse();
    @(negedge ref_clk);
    gq.push_back(gap);
    gq.push_back(gap);
    pulse();
    pulse();
    if (center_mode_select == ATB_CMS_EDGE) check({33'h0, count_down_out}, {33'h0, dir});
    wr(ATB_CTRL_OFF, 32'h0);
    $display("mode %0h dir %0h psc %0d arr %0d rep %0d done", center_mode_select, dir, p, a, r);
  endtask : run_mode

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int m, p, a, r, k;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(ATB_CTRL_OFF, 32'h0);
    rd(ATB_FLAG_OFF, 32'h0);
    rd(ATB_CNT_OFF, 32'h0);
    rd(ATB_PSC_OFF, 32'h0);
    rd(ATB_ARR_OFF, 32'(ATB_ARR_RST));
    rd(ATB_RCR_OFF, 32'h0);
    rd(8'h1C, 32'h0, ATB_RESP_ERR);
    wr(8'h20, 32'h5, ATB_RESP_ERR);
    $display("reset and map test done");
    for (m = 0; m < 5; m++) begin
      seed = lfsr(seed);
      p = int'(seed % 3);
      a = 3 + int'(seed % 6);
      r = (m == 0) ? 1 + int'(seed[0]) : 0;
      if (m < 2) run_mode(ATB_CMS_EDGE, m[0], p, a, r, (r + 1) * (p + 1) * (a + 1));
      else run_mode(2'(m - 1), 1'b0, p, a, 0, a * (p + 1));
    end
    c = '0;
    c.auto_reload_preload_enable = 1'b1;
    c.dir = 1'b1;
    c.update_request_select = 1'b1;
    wr(ATB_CTRL_OFF, 32'(c));
    wr(ATB_ARR_OFF, 32'h7);
    wr(ATB_CNT_OFF, 32'h5);
    wr(ATB_FLAG_OFF, 32'h0);
    wr(ATB_EGR_OFF, 32'h1);
    rd(ATB_FLAG_OFF, 32'h0);
    rd(ATB_CNT_OFF, 32'h7);
    rd(ATB_ARR_OFF, 32'h7);
    c.update_request_select = 1'b0;
    c.dir = 1'b0;
    wr(ATB_CTRL_OFF, 32'(c));
    wr(ATB_CNT_OFF, 32'h5);
    wr(ATB_EGR_OFF, 32'h1);
    rd(ATB_FLAG_OFF, 32'h1);
    rd(ATB_CNT_OFF, 32'h0);
    rd(ATB_EGR_OFF, 32'h0);
    $display("software update test done");
    c = '0;
    c.counter_enable_bit = 1'b1;
    c.update_disable = 1'b1;
    wr(ATB_ARR_OFF, 32'h5);
    wr(ATB_CTRL_OFF, 32'(c));
    @(negedge ref_clk);
    k = npulse;
    repeat (40) @(posedge ref_clk);
    @(negedge ref_clk);
    check(34'(npulse - k), 34'h0);
    @(posedge ref_clk);
    c.update_disable = 1'b0;
    wr(ATB_CTRL_OFF, 32'(c));
    pulse();
    $display("update disable test done");
    conclude();
  end
endmodule : advanced_timer_time_base_bench
`default_nettype wire
